// [stats_pkg.sv]
package stats_pkg;
  localparam int PORTS          = 4;
  localparam int PORT_W         = 2;
  localparam int CNT_PER_PORT   = 8;
  localparam int PORT_CNTS      = PORTS * CNT_PER_PORT;
  localparam int ENTRIES        = 16;
  localparam int ENTRY_W        = 4;
  localparam int SVC_TYPES      = 6;
  localparam int WIDE_SVC_TYPES = 3;
  localparam int SVC_CNTS       = ENTRIES * SVC_TYPES;
  localparam int EVENT_W        = 12;
  localparam int STICKY_GLOBALS = 4;
  localparam int STICKY_SRC_W   = 8;
  localparam int POLICER_EV_W   = 8;
  localparam int LEN_W          = 14;
  localparam int VID_W          = 12;
  localparam int PRIO_W         = 3;
  localparam int COS_W          = 3;
  localparam int ADDR_W         = 12;
  localparam int DATA_W         = 32;
  localparam int WIDE_W         = 40;
  localparam int HIGH_W         = 8;
  localparam int SVC_EV_W       = 6;
  localparam int PORT_CFG_W     = 13;
  // device register map
  localparam logic [11:0] CTRL_OFF         = 12'h000;
  localparam logic [11:0] STICKY_MASK_BASE = 12'h040;
  localparam logic [11:0] PORT_EVMASK_BASE = 12'h080;
  localparam logic [11:0] SVC_CFG_BASE     = 12'h0c0;
  localparam logic [11:0] PORT_CFG_BASE    = 12'h100;
  localparam logic [11:0] PORT_STICKY_BASE = 12'h200;
  localparam logic [11:0] PORT_CNT_BASE    = 12'h400;
  localparam logic [11:0] SVC_CNT_BASE     = 12'h800;
  // control word fields
  localparam int CTRL_PORT_INIT_BIT = 0;
  localparam int CTRL_SVC_INIT_BIT  = 1;
  localparam int CTRL_VLAN_IDX_BIT  = 2;
  localparam int CTRL_POL_COL_BIT   = 3;
  localparam int CTRL_MAP_LSB       = 4;
  localparam logic [7:0] MAP_RESET  = 8'ha4;
  // port counter config fields
  localparam int CFG_KIND_LSB  = 8;
  localparam int CFG_BYTES_BIT = 12;
  localparam logic [12:0] PORT_CFG_RESET = 13'h00ff;
  // service config fields
  localparam int SVC_BYTES_BIT = 8;
  // frame kind codes
  localparam logic [2:0] KIND_OK_NOMATCH  = 3'h0;
  localparam logic [2:0] KIND_OK_MATCH    = 3'h1;
  localparam logic [2:0] KIND_ERR_MATCH   = 3'h2;
  localparam logic [2:0] KIND_MATCH       = 3'h3;
  localparam logic [2:0] KIND_ERR_NOMATCH = 3'h4;
  localparam logic [2:0] KIND_ERR         = 3'h5;
  // colours and cast
  localparam logic [1:0] COL_GREEN  = 2'h0;
  localparam logic [1:0] COL_YELLOW = 2'h1;
  localparam logic [1:0] COL_RED    = 2'h2;
  localparam logic [1:0] CAST_UNI   = 2'h0;
  localparam logic [1:0] CAST_MULTI = 2'h1;
  localparam logic [1:0] CAST_FLOOD = 2'h2;
  // controller register map
  localparam logic [3:0] HREG_ADDR = 4'h0;
  localparam logic [3:0] HREG_DLO  = 4'h4;
  localparam logic [3:0] HREG_DHI  = 4'h8;
  localparam logic [3:0] HREG_CMD  = 4'hc;
  localparam int HCMD_GO_BIT = 0;
  localparam int HCMD_WR_BIT = 1;
  typedef enum logic [3:0] {
    H_IDLE   = 4'b0001,
    H_FIRST  = 4'b0010,
    H_SECOND = 4'b0100,
    H_LAST   = 4'b1000
  } host_state_t;
endpackage : stats_pkg

// [stats_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface stats_link_if
  import stats_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn
);
  logic                    frame_valid;
  logic [PORT_W-1:0]       frame_port;
  logic [PRIO_W-1:0]       frame_prio;
  logic                    frame_error;
  logic                    frame_no_dest;
  logic [LEN_W-1:0]        frame_len;
  logic [STICKY_SRC_W-1:0] frame_sticky;
  logic [POLICER_EV_W-1:0] frame_policer_events;
  logic [1:0]              frame_colour;
  logic [1:0]              frame_drop_precedence;
  logic [1:0]              frame_cast;
  logic [VID_W-1:0]        frame_vlan_id;
  logic [ENTRY_W-1:0]      frame_entry_base;
  logic [COS_W-1:0]        frame_class_offset;
  logic [ADDR_W-1:0]       reg_addr;
  logic [DATA_W-1:0]       reg_wdata;
  logic                    reg_wr;
  logic                    reg_rd;
  logic [DATA_W-1:0]       reg_rdata;
  modport dev (
    input  frame_valid, frame_port, frame_prio, frame_error, frame_no_dest, frame_len,
    input  frame_sticky, frame_policer_events, frame_colour, frame_drop_precedence,
    input  frame_cast, frame_vlan_id, frame_entry_base, frame_class_offset,
    input  reg_addr, reg_wdata, reg_wr, reg_rd,
    output reg_rdata
  );
  modport host (
    output frame_valid, frame_port, frame_prio, frame_error, frame_no_dest, frame_len,
    output frame_sticky, frame_policer_events, frame_colour, frame_drop_precedence,
    output frame_cast, frame_vlan_id, frame_entry_base, frame_class_offset,
    output reg_addr, reg_wdata, reg_wr, reg_rd,
    input  reg_rdata
  );
endinterface : stats_link_if
`default_nettype wire

// [stats_device.sv]
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [R1] event vector: sticky bits, then port policer bits
// [R2] sticky masks route conditions onto global events
// [R3] init clears all port counters and stickies
// [R4] counter considered when priority mask bit set
// [R5] event match is nonzero AND with shared mask
// [R6] frame kind codes select error/match combinations
// [R7] frame without destination counts as errored
// [R8] byte mode adds length, else adds one
// [R9] low read latches high byte into shadow
// [R10] port counter writes go low then high
// [R11] service counter writes go high then low
// [R12] six service types: three wide, three narrow
// [R13] entry from base plus offset, or vlan id
// [R14] per type global bytes or frames choice
// [R15] service event bits: colours then cast kinds
// [R16] one event mask per service type
// [R17] colour from precedence or service policer
// [R18] precedence to colour map is configurable
// [R19] separate init clears all service counters
// [R20] kinds 6 and 7 never count; counters wrap
module stats_device
  import stats_pkg::*;
(
  input  wire logic     mclk,
  input  wire logic     rstn,
  stats_link_if.dev     link,
  output logic [PORTS-1:0] port_sticky_any
);
  logic [STICKY_SRC_W-1:0] sticky_mask_q [STICKY_GLOBALS];
  logic [EVENT_W-1:0]      evmask_q [CNT_PER_PORT];
  logic [SVC_EV_W-1:0]     svc_mask_q [SVC_TYPES];
  logic [SVC_TYPES-1:0]    svc_bytes_q;
  logic [PORT_CFG_W-1:0]   port_cfg_q [PORT_CNTS];
  logic [CNT_PER_PORT-1:0] sticky_q [PORTS];
  logic [WIDE_W-1:0]       port_cnt_q [PORT_CNTS];
  logic [WIDE_W-1:0]       svc_cnt_q [SVC_CNTS];
  logic                    vlan_en_q;
  logic                    pol_sel_q;
  logic [7:0]              map_q;
  logic [DATA_W-1:0]       stage_lo_q;
  logic [HIGH_W-1:0]       stage_hi_q;
  logic [HIGH_W-1:0]       shadow_q;
  logic [DATA_W-1:0]       rdata_q;
  logic [DATA_W-1:0]       rdata_d;
  logic [EVENT_W-1:0]      gev;
  logic [PORT_CNTS-1:0]    port_hit;
  logic [SVC_CNTS-1:0]     svc_hit;
  logic [ENTRY_W-1:0]      entry;
  logic [1:0]              colour;
  logic [SVC_EV_W-1:0]     sev;
  logic                    frame_err;
  logic [ADDR_W-1:0]       a;
  logic                    in_ctrl, in_smask, in_evmask, in_scfg, in_pcfg, in_stk;
  logic                    in_pcnt, in_scnt;
  logic [4:0]              pidx;
  logic [6:0]              sidx;
  logic [2:0]              stype;
  logic                    port_init, svc_init;

  // address decode
  assign a         = link.reg_addr;
  assign in_ctrl   = a == CTRL_OFF;
  assign in_smask  = a[11:4] == STICKY_MASK_BASE[11:4];
  assign in_evmask = a[11:5] == PORT_EVMASK_BASE[11:5];
  assign in_scfg   = a[11:5] == SVC_CFG_BASE[11:5] && a[4:2] < 3'(SVC_TYPES);
  assign in_pcfg   = a[11:7] == PORT_CFG_BASE[11:7];
  assign in_stk    = a[11:4] == PORT_STICKY_BASE[11:4];
  assign in_pcnt   = a[11:8] == PORT_CNT_BASE[11:8];
  assign stype     = a[5:3];
  assign in_scnt   = a[11:10] == SVC_CNT_BASE[11:10] && stype < 3'(SVC_TYPES)
                     && !(a[2] && stype >= 3'(WIDE_SVC_TYPES));
  assign pidx      = a[7:3];
  assign sidx      = 7'(a[9:6] * SVC_TYPES + stype);
  assign port_init = link.reg_wr && in_ctrl && link.reg_wdata[CTRL_PORT_INIT_BIT]; // see [R3]
  assign svc_init  = link.reg_wr && in_ctrl && link.reg_wdata[CTRL_SVC_INIT_BIT];  // see [R19]

  // global event vector
  always_comb begin
    gev = {link.frame_policer_events, {STICKY_GLOBALS{1'b0}}}; // see [R1]
    for (int b = 0; b < STICKY_GLOBALS; b++) begin
      gev[b] = |(link.frame_sticky & sticky_mask_q[b]); // see [R2]
    end
  end
  assign frame_err = link.frame_error | link.frame_no_dest; // see [R7]

  genvar g;
  generate
    for (g = 0; g < PORT_CNTS; g++) begin : g_port
      logic m;
      logic c;
      logic [PORT_CFG_W-1:0] cfg;
      assign cfg = port_cfg_q[g];
      always_comb begin
        m = |(gev & evmask_q[g % CNT_PER_PORT]); // see [R5]
        case (cfg[CFG_KIND_LSB +: 3]) // see [R6]
          KIND_OK_NOMATCH:  c = !frame_err && !m;
          KIND_OK_MATCH:    c = !frame_err && m;
          KIND_ERR_MATCH:   c = frame_err && m;
          KIND_MATCH:       c = m;
          KIND_ERR_NOMATCH: c = frame_err && !m;
          KIND_ERR:         c = frame_err;
          default:          c = 1'b0; // see [R20]
        endcase
      end
      assign port_hit[g] = link.frame_valid && c
                           && link.frame_port == PORT_W'(g / CNT_PER_PORT)
                           && cfg[link.frame_prio]; // see [R4]
    end
    for (g = 0; g < SVC_CNTS; g++) begin : g_svc
      assign svc_hit[g] = link.frame_valid && entry == ENTRY_W'(g / SVC_TYPES)
                          && |(sev & svc_mask_q[g % SVC_TYPES]); // see [R15] [R16]
    end
  endgenerate

  // service entry and events
  always_comb begin
    if (vlan_en_q) begin
      entry = link.frame_vlan_id[ENTRY_W-1:0]; // see [R13]
    end else begin
      entry = ENTRY_W'(link.frame_entry_base + ENTRY_W'(link.frame_class_offset));
    end
    if (pol_sel_q) begin
      colour = link.frame_colour; // see [R17]
    end else begin
      colour = map_q[2*link.frame_drop_precedence +: 2]; // see [R18]
    end
    sev = '0;
    sev[0] = colour == COL_GREEN;
    sev[1] = colour == COL_YELLOW;
    sev[2] = colour == COL_RED;
    sev[3] = link.frame_cast == CAST_UNI;
    sev[4] = link.frame_cast == CAST_MULTI;
    sev[5] = link.frame_cast == CAST_FLOOD;
  end

  // configuration registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      vlan_en_q   <= 1'b0;
      pol_sel_q   <= 1'b0;
      map_q       <= MAP_RESET;
      svc_bytes_q <= '0;
      for (int i = 0; i < STICKY_GLOBALS; i++) sticky_mask_q[i] <= '0;
      for (int i = 0; i < CNT_PER_PORT; i++) evmask_q[i] <= '0;
      for (int i = 0; i < SVC_TYPES; i++) svc_mask_q[i] <= '0;
      for (int i = 0; i < PORT_CNTS; i++) port_cfg_q[i] <= PORT_CFG_RESET;
    end else if (link.reg_wr) begin
      if (in_ctrl) begin
        vlan_en_q <= link.reg_wdata[CTRL_VLAN_IDX_BIT];
        pol_sel_q <= link.reg_wdata[CTRL_POL_COL_BIT];
        map_q     <= link.reg_wdata[CTRL_MAP_LSB +: 8];
      end
      if (in_smask) sticky_mask_q[a[3:2]] <= link.reg_wdata[STICKY_SRC_W-1:0];
      if (in_evmask) evmask_q[a[4:2]] <= link.reg_wdata[EVENT_W-1:0];
      if (in_scfg) begin
        svc_mask_q[a[4:2]]  <= link.reg_wdata[SVC_EV_W-1:0];
        svc_bytes_q[a[4:2]] <= link.reg_wdata[SVC_BYTES_BIT]; // see [R14]
      end
      if (in_pcfg) port_cfg_q[a[6:2]] <= link.reg_wdata[PORT_CFG_W-1:0];
    end
  end

  // per-port sticky bits: a hit in a write-clear cycle survives; port init clears it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int p = 0; p < PORTS; p++) sticky_q[p] <= '0;
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        if (port_init) begin
          sticky_q[p] <= '0; // see [R3]
        end else begin
          sticky_q[p] <= (sticky_q[p]
                          & ~((link.reg_wr && in_stk && a[3:2] == 2'(p))
                              ? link.reg_wdata[CNT_PER_PORT-1:0] : '0))
                         | port_hit[p*CNT_PER_PORT +: CNT_PER_PORT];
        end
      end
    end
  end
  always_comb begin
    for (int p = 0; p < PORTS; p++) port_sticky_any[p] = |sticky_q[p];
  end

  // write staging keeps each 40-bit update atomic
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stage_lo_q <= '0;
      stage_hi_q <= '0;
    end else if (link.reg_wr) begin
      if (in_pcnt && !a[2]) stage_lo_q <= link.reg_wdata; // see [R10]
      if (in_scnt && a[2]) stage_hi_q <= link.reg_wdata[HIGH_W-1:0]; // see [R11]
    end
  end

  // port counters: software write beats a frame update in the same cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < PORT_CNTS; i++) port_cnt_q[i] <= '0;
    end else begin
      for (int i = 0; i < PORT_CNTS; i++) begin
        if (port_init) begin
          port_cnt_q[i] <= '0; // see [R3]
        end else if (link.reg_wr && in_pcnt && a[2] && pidx == 5'(i)) begin
          port_cnt_q[i] <= {link.reg_wdata[HIGH_W-1:0], stage_lo_q}; // see [R10]
        end else if (port_hit[i]) begin
          port_cnt_q[i] <= port_cnt_q[i] + (port_cfg_q[i][CFG_BYTES_BIT] // see [R8] [R20]
                           ? WIDE_W'(link.frame_len) : WIDE_W'(1));
        end
      end
    end
  end

  // service counters; narrow types keep their top byte at zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < SVC_CNTS; i++) svc_cnt_q[i] <= '0;
    end else begin
      for (int i = 0; i < SVC_CNTS; i++) begin
        if (svc_init) begin
          svc_cnt_q[i] <= '0; // see [R19]
        end else if (link.reg_wr && in_scnt && !a[2] && sidx == 7'(i)) begin
          svc_cnt_q[i] <= {(i % SVC_TYPES < WIDE_SVC_TYPES) ? stage_hi_q : 8'h00,
                           link.reg_wdata}; // see [R11] [R12]
        end else if (svc_hit[i]) begin
          svc_cnt_q[i] <= (svc_cnt_q[i] + (svc_bytes_q[i % SVC_TYPES] // see [R14] [R20]
                           ? WIDE_W'(link.frame_len) : WIDE_W'(1)))
                          & ((i % SVC_TYPES < WIDE_SVC_TYPES) ? {WIDE_W{1'b1}}
                             : {{HIGH_W{1'b0}}, {DATA_W{1'b1}}}); // see [R12]
        end
      end
    end
  end

  // read path
  always_comb begin
    rdata_d = '0;
    if (in_ctrl) begin
      rdata_d[CTRL_VLAN_IDX_BIT]     = vlan_en_q;
      rdata_d[CTRL_POL_COL_BIT]      = pol_sel_q;
      rdata_d[CTRL_MAP_LSB +: 8]     = map_q;
    end else if (in_smask) begin
      rdata_d[STICKY_SRC_W-1:0] = sticky_mask_q[a[3:2]];
    end else if (in_evmask) begin
      rdata_d[EVENT_W-1:0] = evmask_q[a[4:2]];
    end else if (in_scfg) begin
      rdata_d[SVC_EV_W-1:0]  = svc_mask_q[a[4:2]];
      rdata_d[SVC_BYTES_BIT] = svc_bytes_q[a[4:2]];
    end else if (in_pcfg) begin
      rdata_d[PORT_CFG_W-1:0] = port_cfg_q[a[6:2]];
    end else if (in_stk) begin
      rdata_d[CNT_PER_PORT-1:0] = sticky_q[a[3:2]];
    end else if (in_pcnt) begin
      rdata_d = a[2] ? {24'h00_0000, shadow_q} : port_cnt_q[pidx][DATA_W-1:0];
    end else if (in_scnt) begin
      rdata_d = a[2] ? {24'h00_0000, shadow_q} : svc_cnt_q[sidx][DATA_W-1:0];
    end
  end

  // shadow of the top byte, caught by the low-word read
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      shadow_q <= '0;
    end else if (link.reg_rd && !a[2]) begin
      if (in_pcnt) shadow_q <= port_cnt_q[pidx][WIDE_W-1:DATA_W]; // see [R9]
      if (in_scnt) shadow_q <= svc_cnt_q[sidx][WIDE_W-1:DATA_W];  // see [R9]
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= link.reg_rd ? rdata_d : '0;
    end
  end
  assign link.reg_rdata = rdata_q;
endmodule : stats_device
`default_nettype wire

// [stats_host.sv]
`timescale 1ns/1ps
`default_nettype none
module stats_host
  import stats_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    rstn,
  stats_link_if.host                   link,
  input  wire logic                    in_valid,
  input  wire logic [PORT_W-1:0]       in_port,
  input  wire logic [PRIO_W-1:0]       in_prio,
  input  wire logic                    in_error,
  input  wire logic                    in_no_dest,
  input  wire logic [LEN_W-1:0]        in_len,
  input  wire logic [STICKY_SRC_W-1:0] in_sticky,
  input  wire logic [POLICER_EV_W-1:0] in_policer_events,
  input  wire logic [1:0]              in_colour,
  input  wire logic [1:0]              in_drop_precedence,
  input  wire logic [1:0]              in_cast,
  input  wire logic [VID_W-1:0]        in_vlan_id,
  input  wire logic [ENTRY_W-1:0]      in_entry_base,
  input  wire logic [COS_W-1:0]        in_class_offset,
  input  wire logic [3:0]              sw_addr,
  input  wire logic [DATA_W-1:0]       sw_wdata,
  input  wire logic                    sw_wr,
  input  wire logic                    sw_rd,
  output logic [DATA_W-1:0]            sw_rdata
);
  host_state_t       state_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] dlo_q;
  logic [DATA_W-1:0] dhi_q;
  logic              write_q;
  logic              pair, svc, low_first, go;
  logic [ADDR_W-1:0] lo_addr, hi_addr;

  assign pair      = addr_q[11:10] != 2'b00;
  assign svc       = addr_q[11];
  assign low_first = !write_q || !svc; // see [R9] [R10] [R11]
  assign lo_addr   = {addr_q[ADDR_W-1:3], 3'b000};
  assign hi_addr   = {addr_q[ADDR_W-1:3], 3'b100};
  assign go        = sw_wr && sw_addr == HREG_CMD && sw_wdata[HCMD_GO_BIT]
                     && state_q == H_IDLE;

  // frame descriptor is registered straight through
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      link.frame_valid <= 1'b0;
      link.frame_port <= '0;
      link.frame_prio <= '0;
      link.frame_error <= 1'b0;
      link.frame_no_dest <= 1'b0;
      link.frame_len <= '0;
      link.frame_sticky <= '0;
      link.frame_policer_events <= '0;
      link.frame_colour <= '0;
      link.frame_drop_precedence <= '0;
      link.frame_cast <= '0;
      link.frame_vlan_id <= '0;
      link.frame_entry_base <= '0;
      link.frame_class_offset <= '0;
    end else begin
      link.frame_valid <= in_valid;
      link.frame_port <= in_port;
      link.frame_prio <= in_prio;
      link.frame_error <= in_error;
      link.frame_no_dest <= in_no_dest;
      link.frame_len <= in_len;
      link.frame_sticky <= in_sticky;
      link.frame_policer_events <= in_policer_events;
      link.frame_colour <= in_colour;
      link.frame_drop_precedence <= in_drop_precedence;
      link.frame_cast <= in_cast;
      link.frame_vlan_id <= in_vlan_id;
      link.frame_entry_base <= in_entry_base;
      link.frame_class_offset <= in_class_offset;
    end
  end

  // access sequencer: a counter access is two bus cycles back to back
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q        <= H_IDLE;
      link.reg_wr    <= 1'b0;
      link.reg_rd    <= 1'b0;
      link.reg_addr  <= '0;
      link.reg_wdata <= '0;
    end else begin
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
      case (state_q)
        H_IDLE: begin
          if (go) begin
            link.reg_wr    <= sw_wdata[HCMD_WR_BIT];
            link.reg_rd    <= !sw_wdata[HCMD_WR_BIT];
            link.reg_addr  <= !pair ? addr_q
                              : (!sw_wdata[HCMD_WR_BIT] || !svc) ? lo_addr : hi_addr;
            link.reg_wdata <= (!pair || !sw_wdata[HCMD_WR_BIT] || !svc) ? dlo_q : dhi_q;
            state_q <= pair ? H_SECOND : (sw_wdata[HCMD_WR_BIT] ? H_IDLE : H_FIRST);
          end
        end
        H_SECOND: begin
          link.reg_wr    <= write_q;
          link.reg_rd    <= !write_q;
          link.reg_addr  <= low_first ? hi_addr : lo_addr;
          link.reg_wdata <= low_first ? dhi_q : dlo_q;
          state_q <= write_q ? H_IDLE : H_FIRST;
        end
        H_FIRST: state_q <= H_LAST; // device answers a cycle after the strobe
        H_LAST:  state_q <= H_IDLE;
        default: state_q <= H_IDLE;
      endcase
    end
  end

  // software registers, with read results captured from the device
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      addr_q  <= '0;
      dlo_q   <= '0;
      dhi_q   <= '0;
      write_q <= 1'b0;
    end else begin
      if (sw_wr && state_q == H_IDLE) begin
        if (sw_addr == HREG_ADDR) addr_q <= sw_wdata[ADDR_W-1:0];
        if (sw_addr == HREG_DLO) dlo_q <= sw_wdata;
        if (sw_addr == HREG_DHI) dhi_q <= sw_wdata;
      end
      if (go) write_q <= sw_wdata[HCMD_WR_BIT];
      if (state_q == H_FIRST && pair) dlo_q <= link.reg_rdata;
      if (state_q == H_LAST) begin
        if (pair) begin
          dhi_q <= link.reg_rdata; // see [R9]
        end else begin
          dlo_q <= link.reg_rdata;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sw_rdata <= '0;
    end else if (sw_rd) begin
      case (sw_addr)
        HREG_ADDR: sw_rdata <= {{(DATA_W-ADDR_W){1'b0}}, addr_q};
        HREG_DLO:  sw_rdata <= dlo_q;
        HREG_DHI:  sw_rdata <= dhi_q;
        HREG_CMD:  sw_rdata <= {{(DATA_W-1){1'b0}}, state_q != H_IDLE};
        default:   sw_rdata <= '0;
      endcase
    end else begin
      sw_rdata <= '0;
    end
  end
endmodule : stats_host
`default_nettype wire

// [stats_link_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module stats_link_chk
  import stats_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rstn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // counter space decode; service counters live in the upper half
  wire logic cnt = reg_addr[11:10] != 2'b00;
  wire logic svc = reg_addr[11];
  property p_idle; !reg_rd |=> reg_rdata == '0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside its slot");
  property p_pair_rd; reg_rd && cnt && !reg_addr[2] |=> reg_rd && reg_addr == $past(reg_addr) + 12'h004; endproperty
  a_pair_rd: assert property (p_pair_rd) else $error("high read not next");
  property p_hi_byte; reg_rd && cnt && reg_addr[2] |=> reg_rdata[31:8] == '0; endproperty
  a_hi_byte: assert property (p_hi_byte) else $error("high word wider than a byte");
  property p_port_wr; reg_wr && reg_addr[11:10] == 2'b01 && !reg_addr[2] |=> reg_wr && reg_addr == $past(reg_addr) + 12'h004; endproperty
  a_port_wr: assert property (p_port_wr) else $error("port write order");
  property p_svc_wr; reg_wr && svc && reg_addr[2] && reg_addr[5:3] < 3'h3 |=> reg_wr && reg_addr == $past(reg_addr) - 12'h004; endproperty
  a_svc_wr: assert property (p_svc_wr) else $error("service write order");
  property p_init; reg_rd && reg_addr == CTRL_OFF |=> reg_rdata[1:0] == 2'b00; endproperty
  a_init: assert property (p_init) else $error("init bits stuck");
  property p_types; reg_rd && svc && reg_addr[5:4] == 2'b11 |=> reg_rdata == '0; endproperty
  a_types: assert property (p_types) else $error("seventh type answered");
  property p_narrow; reg_rd && svc && reg_addr[2] && reg_addr[5:3] inside {3'h3, 3'h4, 3'h5} |=> reg_rdata == '0; endproperty
  a_narrow: assert property (p_narrow) else $error("narrow counter has high byte");
endmodule : stats_link_chk
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module testbench
  import stats_pkg::*;
;
  logic        mclk = 0, rstn = 0, v = 0, er = 0, nd = 0, sw_wr = 0, sw_rd = 0;
  logic [1:0]  pt = 0, col = 0, dp = 0, cs = 0, rc;
  logic [2:0]  pr = 0, off = 0;
  logic [3:0]  base = 0, sw_addr = 0, sps;
  logic [7:0]  stk = 0, pol = 0;
  logic [11:0] vid = 0, em [8];
  logic [13:0] len = 0;
  logic [31:0] sw_wdata = 0, sw_rdata, rdv, lo, hi;
  logic [39:0] pc [32], sc [96];
  logic [5:0]  sm [6], sb;
  int          fail_count = 0, num_checks = 0;
  always #10 mclk = ~mclk;
  stats_link_if link (.mclk(mclk), .rstn(rstn));
  stats_device stats_device_inst (.mclk(mclk), .rstn(rstn), .link(link), .port_sticky_any(sps));
  stats_host stats_host_inst (.mclk(mclk), .rstn(rstn), .link(link), .in_valid(v),
    .in_port(pt), .in_prio(pr), .in_error(er), .in_no_dest(nd), .in_len(len),
    .in_sticky(stk), .in_policer_events(pol), .in_colour(col), .in_drop_precedence(dp),
    .in_cast(cs), .in_vlan_id(vid), .in_entry_base(base), .in_class_offset(off),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  stats_link_chk stats_link_chk_inst (.mclk(mclk), .rstn(rstn), .reg_addr(link.reg_addr),
    .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata));
  task automatic sw(input logic [3:0] a, input logic [31:0] d, input logic w);
    @(posedge mclk);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= w;
    sw_rd    <= !w;
    @(posedge mclk);
    sw_wr    <= 1'b0;
    sw_rd    <= 1'b0;
    #1 rdv = sw_rdata;
  endtask : sw
  // one device access through the controller; polling is bounded so a hang shows
  task automatic acc(input logic [11:0] a, input logic w, input logic [39:0] d);
    int n;
    sw(HREG_ADDR, 32'(a), 1);
    sw(HREG_DLO, d[31:0], 1);
    sw(HREG_DHI, 32'(d[39:32]), 1);
    sw(HREG_CMD, {30'h0, w, 1'b1}, 1);
    n = 0;
    do begin sw(HREG_CMD, 0, 0); n++; end while (rdv[0] !== 1'b0 && n < 50);
    if (rdv[0] !== 1'b0) fail_count++;
    sw(HREG_DLO, 0, 0);
    lo = rdv;
    sw(HREG_DHI, 0, 0);
    hi = rdv;
  endtask : acc
  task automatic frame();
    logic [11:0] ev;
    logic        e, m, c;
    logic [3:0]  en;
    logic [5:0]  se;
    @(posedge mclk);
    {pt, pr, er, nd, len, stk, pol, dp, vid, base, off} <= 58'({$urandom(), $urandom()});
    col <= 2'($urandom() % 3);
    cs  <= 2'($urandom() % 3);
    v   <= 1'b1;
    #1 ev = {pol, 3'b000, stk[0]};
    e = er | nd;
    for (int i = 0; i < 8; i++) begin
      m = |(ev & em[i]);
      c = (i == 0 && !e && !m) || (i == 1 && !e && m) || (i == 2 && e && m)
        || (i == 3 && m) || (i == 4 && e && !m) || (i == 5 && e);
      if (c && !(i[0] && pr == 3'h7)) pc[pt*8+i] += i[1] ? 40'(len) : 40'h1;
    end
    en = rc[0] ? vid[3:0] : base + 4'(off);
    se = 6'(1 << (rc[1] ? col : (dp[1] ? 2'h2 : {1'b0, dp[0]}))) | 6'(8 << cs);
    for (int i = 0; i < 6; i++) if (|(se & sm[i])) begin
      sc[en*6+i] += sb[i] ? 40'(len) : 40'h1;
      if (i > 2) sc[en*6+i][39:32] = 8'h00;
    end
  endtask : frame
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (50000) @(posedge mclk);
    fail_count++;
    close_out();
  end
  initial begin
    void'($urandom(74944));
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    for (int k = 0; k < 8; k++) em[k] = 12'($urandom());
    for (int t = 0; t < 6; t++) sm[t] = 6'($urandom());
    sb = 6'($urandom());
    acc(STICKY_MASK_BASE, 1, 40'h01);
    for (int k = 0; k < 8; k++) acc(PORT_EVMASK_BASE + 12'(4*k), 1, 40'(em[k]));
    for (int t = 0; t < 6; t++) acc(SVC_CFG_BASE + 12'(4*t), 1, 40'({sb[t], 2'b00, sm[t]}));
    for (int i = 0; i < 32; i++)
      acc(PORT_CFG_BASE + 12'(4*i), 1, 40'({i[1], 1'b0, 3'(i), i[0] ? 8'h7f : 8'hff}));
    for (int r = 0; r < 4; r++) begin
      rc = 2'(r);
      acc(CTRL_OFF, 1, 40'({MAP_RESET, rc[1], rc[0], 2'b11}));
      acc(CTRL_OFF, 0, 0);
      `CHK(lo[11:0], {MAP_RESET, rc[1], rc[0], 2'b00})
      `CHK(sps, 4'h0)
      foreach (sc[i]) sc[i] = 40'h0;
      for (int i = 0; i < 32; i++) begin
        acc(PORT_CNT_BASE + 12'(8*i), 1, 40'hff_ffff_fff0);
        pc[i] = 40'hff_ffff_fff0;
      end
      for (int t = 0; t < 6; t++) begin
        acc(SVC_CNT_BASE + 12'(64*r+8*t), 1, 40'hff_ffff_fff0);
        sc[r*6+t] = t < 3 ? 40'hff_ffff_fff0 : 40'hff_ffff_fff0 & 40'hffff_ffff;
      end
      repeat (60) frame();
      @(posedge mclk);
      v <= 1'b0;
      for (int i = 0; i < 32; i++) begin
        acc(PORT_CNT_BASE + 12'(8*i), 0, 0);
        `CHK({hi[7:0], lo}, pc[i])
      end
      for (int i = 0; i < 96; i++) begin
        acc(SVC_CNT_BASE + 12'(64*(i/6)+8*(i%6)), 0, 0);
        `CHK({hi[7:0], lo}, sc[i])
      end
      acc(SVC_CNT_BASE + 12'h030, 0, 0);
      `CHK({hi, lo}, 64'h0)
    end
    close_out();
  end
endmodule : testbench
`default_nettype wire
